// ===== logic/phy_link_pkg.sv
/*
 Constants shared by both ends of the phy-to-link interface: line codes,
 request framing, field layout and reset values.
 Assumes both ends run on one reference clock and share this package.
*/
`default_nettype none
package phy_link_pkg;
	// Control codes are written {line zero, line one}
	localparam logic [1:0] PHY_IDLE = 2'h0;
	localparam logic [1:0] PHY_STATUS = 2'h1;
	localparam logic [1:0] PHY_RECV = 2'h2;
	localparam logic [1:0] PHY_GRANT = 2'h3;
	localparam logic [1:0] LINK_REL = 2'h0;
	localparam logic [1:0] LINK_HOLD = 2'h1;
	localparam logic [1:0] LINK_XMIT = 2'h2;
	localparam logic [2:0] RQ_IMM = 3'h0;
	localparam logic [2:0] RQ_ISO = 3'h1;
	localparam logic [2:0] RQ_PRI = 3'h2;
	localparam logic [2:0] RQ_FAIR = 3'h3;
	localparam logic [2:0] RQ_RD = 3'h4;
	localparam logic [2:0] RQ_WR = 3'h5;
	localparam logic START_BIT = 1'h1;
	localparam logic STOP_BIT = 1'h0;
	localparam logic REQ_IDLE_LEVEL = 1'h0;
	localparam logic [4:0] LEN_CABLE = 5'h07;
	localparam logic [4:0] LEN_BACKPLANE = 5'h0b;
	localparam logic [4:0] LEN_READ = 5'h09;
	localparam logic [4:0] LEN_WRITE = 5'h11;
	localparam logic [4:0] TYPE_LAST_CNT = 5'h03;
	localparam logic [1:0] SPEED_BACKPLANE = 2'h0;
	localparam logic [3:0] PRIO_FAIR = 4'h0;
	localparam logic [3:0] PRIO_RSVD = 4'hf;
	localparam int NUM_REGS = 16;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] STAT_WORDS = 3'h6;
endpackage
`default_nettype wire

// ===== logic/phy_link_if.sv
/*
 Phy-to-link wires: two control lines, two data lines, request line and
 the link clock. Two-way lines are resolved here from the enables.
 Assumes undriven lines read low, so a gap between owners reads idle.
*/
`timescale 1ns/10ps
`default_nettype none
interface phy_link_if;
	logic link_clk;
	logic link_request_line;
	logic [0:1] ctrl_phy;
	logic [0:1] ctrl_phy_oe;
	logic [0:1] data_phy;
	logic [0:1] data_phy_oe;
	logic [0:1] ctrl_link;
	logic [0:1] ctrl_link_oe;
	logic [0:1] data_link;
	logic [0:1] data_link_oe;
	// Index 0 is control_line_zero / data_line_zero
	wire logic [0:1] control_line;
	wire logic [0:1] data_line;
	assign control_line = (ctrl_phy & ctrl_phy_oe) | (ctrl_link & ctrl_link_oe);
	assign data_line = (data_phy & data_phy_oe) | (data_link & data_link_oe);
	modport phy(output link_clk, ctrl_phy, ctrl_phy_oe, data_phy, data_phy_oe,
		input link_request_line, control_line, data_line);
	modport link(output link_request_line, ctrl_link, ctrl_link_oe, data_link, data_link_oe,
		input link_clk, control_line, data_line);
endinterface
`default_nettype wire

// ===== logic/phy_end.sv
/*
 Phy end of the phy-to-link interface: drives the link clock, decodes the
 serial requests, keeps the register file, runs receive, status and grant.
 Assumes the serial-bus side supplies received words and arbitration wins.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_end import phy_link_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	phy_link_if.phy lnk,
	input wire logic backplane_i,
	input wire logic rx_valid_i,
	input wire logic [0:1] rx_data_i,
	input wire logic bus_won_i,
	output logic req_valid_o,
	output logic [2:0] req_type_o,
	output logic [1:0] req_speed_o,
	output logic [3:0] req_prio_o,
	output logic pending_o,
	output logic tx_valid_o,
	output logic [0:1] tx_data_o,
	output logic tx_hold_o
);
	typedef enum logic [2:0] {P_IDLE, P_RECV, P_STAT, P_GRANT, P_WAIT, P_LINK} pstate_e;

	logic clk_r, clk_nxt;
	logic [4:0] s1_r, s1_nxt, s2_r, s2_nxt;
	logic tick, req_s;
	logic [0:1] ctrl_s, dat_s;

	logic rq_act_r, rq_act_nxt;
	logic [4:0] rq_cnt_r, rq_cnt_nxt, rq_len;
	logic [16:0] rq_sh_r, rq_sh_nxt, rq_full;
	logic [2:0] rq_type_r, rq_type_nxt;
	logic frame_done;

	pstate_e st_r, st_nxt;
	logic [0:1] ctrl_r, ctrl_nxt, ctrl_oe_r, ctrl_oe_nxt;
	logic [0:1] dat_r, dat_nxt, dat_oe_r, dat_oe_nxt;
	logic pend_r, pend_nxt, iso_r, iso_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic [3:0] rd_addr_r, rd_addr_nxt;
	logic [11:0] stat_sh_r, stat_sh_nxt;
	logic [2:0] stat_cnt_r, stat_cnt_nxt;
	logic req_valid_r, req_valid_nxt;
	logic [2:0] req_type_r, req_type_nxt;
	logic [1:0] req_speed_r, req_speed_nxt;
	logic [3:0] req_prio_r, req_prio_nxt;
	logic tx_valid_r, tx_valid_nxt, tx_hold_r, tx_hold_nxt;
	logic [0:1] tx_data_r, tx_data_nxt;
	logic [7:0] regs_r [NUM_REGS];
	logic [7:0] regs_nxt [NUM_REGS];

	// Link clock divider and pin synchronisers
	always_comb begin
		clk_nxt = ~clk_r;
		s1_nxt = {lnk.link_request_line, lnk.control_line, lnk.data_line};
		s2_nxt = s1_r;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_r <= 1'b0;
			s1_r <= 5'h00;
			s2_r <= 5'h00;
		end else begin
			clk_r <= clk_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// Work happens on the edge where the link clock rises
	assign tick = ~clk_r;
	assign req_s = s2_r[4];
	assign ctrl_s = s2_r[3:2];
	assign dat_s = s2_r[1:0];
	assign rq_full = {rq_sh_r[15:0], req_s};

	always_comb begin
		case (rq_type_r)
			RQ_RD: rq_len = LEN_READ;
			RQ_WR: rq_len = LEN_WRITE;
			default: rq_len = backplane_i ? LEN_BACKPLANE : LEN_CABLE;
		endcase
	end

	// Serial request deframer
	always_comb begin
		rq_act_nxt = rq_act_r;
		rq_cnt_nxt = rq_cnt_r;
		rq_sh_nxt = rq_sh_r;
		rq_type_nxt = rq_type_r;
		frame_done = 1'b0;
		if (tick) begin
			if (!rq_act_r) begin
				if (req_s == START_BIT) begin
					rq_act_nxt = 1'b1;
					rq_cnt_nxt = 5'h01;
					rq_sh_nxt = 17'h00001;
				end
			end else begin
				rq_sh_nxt = rq_full;
				rq_cnt_nxt = rq_cnt_r + 5'h01;
				if (rq_cnt_r == TYPE_LAST_CNT) begin
					rq_type_nxt = rq_full[2:0];
				end
				// Length is only trusted once the type is in; shortest frame ends well after
				if (rq_cnt_r + 5'h01 == rq_len) begin
					rq_act_nxt = 1'b0;
					frame_done = (req_s == STOP_BIT);
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rq_act_r <= 1'b0;
			rq_cnt_r <= 5'h00;
			rq_sh_r <= 17'h00000;
			rq_type_r <= RQ_IMM;
		end else begin
			rq_act_r <= rq_act_nxt;
			rq_cnt_r <= rq_cnt_nxt;
			rq_sh_r <= rq_sh_nxt;
			rq_type_r <= rq_type_nxt;
		end
	end

	// Request dispatch, register file and interface ownership
	always_comb begin
		st_nxt = st_r;
		ctrl_nxt = ctrl_r;
		ctrl_oe_nxt = ctrl_oe_r;
		dat_nxt = dat_r;
		dat_oe_nxt = dat_oe_r;
		pend_nxt = pend_r;
		iso_nxt = iso_r;
		rd_pend_nxt = rd_pend_r;
		rd_addr_nxt = rd_addr_r;
		stat_sh_nxt = stat_sh_r;
		stat_cnt_nxt = stat_cnt_r;
		req_valid_nxt = 1'b0;
		req_type_nxt = req_type_r;
		req_speed_nxt = req_speed_r;
		req_prio_nxt = req_prio_r;
		tx_valid_nxt = 1'b0;
		tx_data_nxt = tx_data_r;
		tx_hold_nxt = tx_hold_r;
		regs_nxt = regs_r;
		if (frame_done) begin
			case (rq_type_r)
				RQ_RD: begin
					rd_pend_nxt = 1'b1;
					rd_addr_nxt = rq_full[4:1];
				end
				RQ_WR: regs_nxt[rq_full[12:9]] = rq_full[8:1];
				RQ_IMM, RQ_ISO, RQ_PRI, RQ_FAIR: begin
					// A second bus request while one is pending is dropped
					if (!pend_r) begin
						pend_nxt = 1'b1;
						iso_nxt = (rq_type_r == RQ_ISO);
						req_valid_nxt = 1'b1;
						req_type_nxt = rq_type_r;
						if (backplane_i) begin
							req_speed_nxt = SPEED_BACKPLANE;
							// Fair carries the frame's priority, other types get zero; all ones left to the arbiter
							req_prio_nxt = (rq_type_r == RQ_FAIR) ? rq_full[4:1] : PRIO_FAIR;
						end else begin
							req_speed_nxt = rq_full[2:1];
							req_prio_nxt = PRIO_FAIR;
						end
					end
				end
				default: ;
			endcase
		end
		if (tick) begin
			case (st_r)
				P_IDLE, P_RECV, P_STAT: begin
					ctrl_oe_nxt = 2'h3;
					if (rx_valid_i) begin
						st_nxt = P_RECV;
						ctrl_nxt = PHY_RECV;
						dat_nxt = rx_data_i;
						dat_oe_nxt = 2'h3;
						// Lost: isochronous requests survive until won
						if (st_r != P_RECV && !iso_r) begin
							pend_nxt = 1'b0;
						end
					end else if (st_r == P_STAT && stat_cnt_r != STAT_WORDS) begin
						dat_nxt = stat_sh_r[11:10];
						stat_sh_nxt = {stat_sh_r[9:0], 2'h0};
						stat_cnt_nxt = stat_cnt_r + 3'h1;
					end else if (st_r == P_STAT) begin
						st_nxt = P_IDLE;
						// A read landing on the last status word stays pending
						if (!(frame_done && rq_type_r == RQ_RD)) begin
							rd_pend_nxt = 1'b0;
						end
						ctrl_nxt = PHY_IDLE;
						dat_oe_nxt = 2'h0;
					end else if (pend_r && bus_won_i && !frame_done) begin
						st_nxt = P_GRANT;
						ctrl_nxt = PHY_GRANT;
						dat_oe_nxt = 2'h0;
						pend_nxt = 1'b0;
					end else if (rd_pend_r) begin
						st_nxt = P_STAT;
						ctrl_nxt = PHY_STATUS;
						dat_nxt = rd_addr_r[3:2];
						stat_sh_nxt = {rd_addr_r[1:0], regs_r[rd_addr_r], 2'h0};
						stat_cnt_nxt = 3'h1;
						dat_oe_nxt = 2'h3;
					end else begin
						st_nxt = P_IDLE;
						ctrl_nxt = PHY_IDLE;
						dat_oe_nxt = 2'h0;
					end
				end
				P_GRANT: begin
					st_nxt = P_WAIT;
					ctrl_oe_nxt = 2'h0;
				end
				P_WAIT: begin
					// Own grant code still echoes through the synchroniser here
					if (ctrl_s == LINK_HOLD || ctrl_s == LINK_XMIT) begin
						st_nxt = P_LINK;
					end
				end
				P_LINK: begin
					tx_hold_nxt = (ctrl_s == LINK_HOLD);
					if (ctrl_s == LINK_XMIT) begin
						tx_valid_nxt = 1'b1;
						tx_data_nxt = dat_s;
					end else if (ctrl_s == LINK_REL) begin
						st_nxt = P_IDLE;
						ctrl_nxt = PHY_IDLE;
						ctrl_oe_nxt = 2'h3;
						tx_hold_nxt = 1'b0;
					end
				end
				default: st_nxt = P_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= P_IDLE;
			ctrl_r <= PHY_IDLE;
			ctrl_oe_r <= 2'h3;
			dat_r <= 2'h0;
			dat_oe_r <= 2'h0;
			pend_r <= 1'b0;
			iso_r <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_addr_r <= 4'h0;
			stat_sh_r <= 12'h000;
			stat_cnt_r <= 3'h0;
			req_valid_r <= 1'b0;
			req_type_r <= RQ_IMM;
			req_speed_r <= 2'h0;
			req_prio_r <= 4'h0;
			tx_valid_r <= 1'b0;
			tx_data_r <= 2'h0;
			tx_hold_r <= 1'b0;
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_r[i] <= REG_RESET;
			end
		end else begin
			st_r <= st_nxt;
			ctrl_r <= ctrl_nxt;
			ctrl_oe_r <= ctrl_oe_nxt;
			dat_r <= dat_nxt;
			dat_oe_r <= dat_oe_nxt;
			pend_r <= pend_nxt;
			iso_r <= iso_nxt;
			rd_pend_r <= rd_pend_nxt;
			rd_addr_r <= rd_addr_nxt;
			stat_sh_r <= stat_sh_nxt;
			stat_cnt_r <= stat_cnt_nxt;
			req_valid_r <= req_valid_nxt;
			req_type_r <= req_type_nxt;
			req_speed_r <= req_speed_nxt;
			req_prio_r <= req_prio_nxt;
			tx_valid_r <= tx_valid_nxt;
			tx_data_r <= tx_data_nxt;
			tx_hold_r <= tx_hold_nxt;
			regs_r <= regs_nxt;
		end
	end

	assign lnk.link_clk = clk_r;
	assign lnk.ctrl_phy = ctrl_r;
	assign lnk.ctrl_phy_oe = ctrl_oe_r;
	assign lnk.data_phy = dat_r;
	assign lnk.data_phy_oe = dat_oe_r;
	assign req_valid_o = req_valid_r;
	assign req_type_o = req_type_r;
	assign req_speed_o = req_speed_r;
	assign req_prio_o = req_prio_r;
	assign pending_o = pend_r;
	assign tx_valid_o = tx_valid_r;
	assign tx_data_o = tx_data_r;
	assign tx_hold_o = tx_hold_r;
endmodule
`default_nettype wire

// ===== logic/link_end.sv
/*
 Link end of the phy-to-link interface: frames serial requests, follows
 the phy's control codes, delivers received and status words, transmits.
 Assumes the link clock arrives from the phy and is sampled on ref_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module link_end import phy_link_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	phy_link_if.link lnk,
	input wire logic backplane_i,
	input wire logic req_start_i,
	input wire logic [2:0] req_type_i,
	input wire logic [1:0] req_speed_i,
	input wire logic [3:0] req_prio_i,
	input wire logic [3:0] req_addr_i,
	input wire logic [7:0] req_data_i,
	input wire logic tx_valid_i,
	input wire logic [0:1] tx_data_i,
	input wire logic tx_hold_i,
	output logic req_busy_o,
	output logic bus_pending_o,
	output logic granted_o,
	output logic rx_valid_o,
	output logic [0:1] rx_data_o,
	output logic stat_valid_o,
	output logic [3:0] stat_addr_o,
	output logic [7:0] stat_data_o
);
	typedef enum logic [1:0] {L_IDLE, L_OWN, L_REL} lstate_e;

	logic [4:0] s1_r, s2_r;
	logic clk_d_r, tick;
	logic [0:1] ctrl_s, dat_s;
	lstate_e st_r, st_nxt;
	logic [16:0] sh_r, sh_nxt, frame;
	logic [4:0] len_r, len_nxt, cnt_r, cnt_nxt, frame_len;
	logic busy_r, busy_nxt, line_r, line_nxt, pend_r, pend_nxt, gr_r, gr_nxt;
	logic [0:1] ctrl_r, ctrl_nxt, ctrl_oe_r, ctrl_oe_nxt, dat_r, dat_nxt, dat_oe_r, dat_oe_nxt;
	logic rxv_r, rxv_nxt, stv_r, stv_nxt;
	logic [0:1] rxd_r, rxd_nxt;
	logic [11:0] stat_r, stat_nxt;
	logic [2:0] scnt_r, scnt_nxt;

	assign tick = s2_r[4] & ~clk_d_r;
	assign ctrl_s = s2_r[3:2];
	assign dat_s = s2_r[1:0];

	always_comb begin
		case (req_type_i)
			RQ_RD: begin
				frame = {START_BIT, RQ_RD, req_addr_i, STOP_BIT, 8'h00};
				frame_len = LEN_READ;
			end
			RQ_WR: begin
				frame = {START_BIT, RQ_WR, req_addr_i, req_data_i, STOP_BIT};
				frame_len = LEN_WRITE;
			end
			default: begin
				if (backplane_i) begin
					frame = {START_BIT, req_type_i, SPEED_BACKPLANE, req_prio_i, STOP_BIT, 6'h00};
					frame_len = LEN_BACKPLANE;
				end else begin
					frame = {START_BIT, req_type_i, req_speed_i, STOP_BIT, 10'h000};
					frame_len = LEN_CABLE;
				end
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		len_nxt = len_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		line_nxt = line_r;
		pend_nxt = pend_r;
		gr_nxt = gr_r;
		ctrl_nxt = ctrl_r;
		ctrl_oe_nxt = ctrl_oe_r;
		dat_nxt = dat_r;
		dat_oe_nxt = dat_oe_r;
		rxv_nxt = 1'b0;
		rxd_nxt = rxd_r;
		stv_nxt = 1'b0;
		stat_nxt = stat_r;
		scnt_nxt = scnt_r;
		// A start while busy is ignored; the user watches req_busy_o
		if (req_start_i && !busy_r) begin
			busy_nxt = 1'b1;
			sh_nxt = frame;
			len_nxt = frame_len;
			cnt_nxt = 5'h00;
			if (req_type_i[2] == 1'b0) begin
				pend_nxt = 1'b1;
			end
		end else if (tick && busy_r) begin
			if (cnt_r == len_r) begin
				busy_nxt = 1'b0;
				line_nxt = REQ_IDLE_LEVEL;
			end else begin
				line_nxt = sh_r[16];
				sh_nxt = {sh_r[15:0], 1'b0};
				cnt_nxt = cnt_r + 5'h01;
			end
		end
		if (tick) begin
			case (st_r)
				L_IDLE: begin
					ctrl_oe_nxt = 2'h0;
					dat_oe_nxt = 2'h0;
					if (ctrl_s != PHY_STATUS) begin
						scnt_nxt = 3'h0;
					end
					if (ctrl_s == PHY_GRANT) begin
						st_nxt = L_OWN;
						gr_nxt = 1'b1;
						pend_nxt = 1'b0;
						ctrl_nxt = LINK_HOLD;
						ctrl_oe_nxt = 2'h3;
					end else if (ctrl_s == PHY_RECV) begin
						rxv_nxt = 1'b1;
						rxd_nxt = dat_s;
						pend_nxt = 1'b0;
					end else if (ctrl_s == PHY_STATUS) begin
						stat_nxt = {stat_r[9:0], dat_s};
						scnt_nxt = scnt_r + 3'h1;
						if (scnt_r == STAT_WORDS - 3'h1) begin
							stv_nxt = 1'b1;
							scnt_nxt = 3'h0;
						end
					end
				end
				L_OWN: begin
					// Reserved code is never produced
					if (tx_valid_i) begin
						ctrl_nxt = LINK_XMIT;
						dat_nxt = tx_data_i;
						dat_oe_nxt = 2'h3;
					end else if (tx_hold_i) begin
						ctrl_nxt = LINK_HOLD;
						dat_oe_nxt = 2'h0;
					end else begin
						ctrl_nxt = LINK_REL;
						dat_oe_nxt = 2'h0;
						st_nxt = L_REL;
					end
				end
				L_REL: begin
					ctrl_oe_nxt = 2'h0;
					gr_nxt = 1'b0;
					st_nxt = L_IDLE;
				end
				default: st_nxt = L_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
			clk_d_r <= 1'b0;
			st_r <= L_IDLE;
			sh_r <= 17'h00000;
			len_r <= 5'h00;
			cnt_r <= 5'h00;
			busy_r <= 1'b0;
			line_r <= REQ_IDLE_LEVEL;
			pend_r <= 1'b0;
			gr_r <= 1'b0;
			ctrl_r <= LINK_REL;
			ctrl_oe_r <= 2'h0;
			dat_r <= 2'h0;
			dat_oe_r <= 2'h0;
			rxv_r <= 1'b0;
			rxd_r <= 2'h0;
			stv_r <= 1'b0;
			stat_r <= 12'h000;
			scnt_r <= 3'h0;
		end else begin
			s1_r <= {lnk.link_clk, lnk.control_line, lnk.data_line};
			s2_r <= s1_r;
			clk_d_r <= s2_r[4];
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			len_r <= len_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			line_r <= line_nxt;
			pend_r <= pend_nxt;
			gr_r <= gr_nxt;
			ctrl_r <= ctrl_nxt;
			ctrl_oe_r <= ctrl_oe_nxt;
			dat_r <= dat_nxt;
			dat_oe_r <= dat_oe_nxt;
			rxv_r <= rxv_nxt;
			rxd_r <= rxd_nxt;
			stv_r <= stv_nxt;
			stat_r <= stat_nxt;
			scnt_r <= scnt_nxt;
		end
	end

	assign lnk.link_request_line = line_r;
	assign lnk.ctrl_link = ctrl_r;
	assign lnk.ctrl_link_oe = ctrl_oe_r;
	assign lnk.data_link = dat_r;
	assign lnk.data_link_oe = dat_oe_r;
	assign req_busy_o = busy_r;
	assign bus_pending_o = pend_r;
	assign granted_o = gr_r;
	assign rx_valid_o = rxv_r;
	assign rx_data_o = rxd_r;
	assign stat_valid_o = stv_r;
	assign stat_addr_o = stat_r[11:8];
	assign stat_data_o = stat_r[7:0];
endmodule
`default_nettype wire

// ===== sim/phy_link_assertions.sv
/*
 Checker for the phy-to-link wires: ownership, line codes, grant timing,
 request bit timing and the link clock.
 Assumes the testbench instantiates it beside the interface on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_link_assertions import phy_link_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic link_clk,
	input wire logic link_request_line,
	input wire logic [0:1] ctrl_phy,
	input wire logic [0:1] ctrl_phy_oe,
	input wire logic [0:1] ctrl_link,
	input wire logic [0:1] ctrl_link_oe,
	input wire logic [0:1] data_link_oe,
	input wire logic [0:1] control_line
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic grant_drv;
	logic link_owns;
	assign grant_drv = (ctrl_phy_oe == 2'b11) && (ctrl_phy == PHY_GRANT);
	assign link_owns = (ctrl_link_oe != 2'b00);
	a_single_owner: assert property (link_owns |-> ctrl_phy_oe == 2'b00)
		else $error("link and phy drive the control lines together");
	a_link_data_owned: assert property (data_link_oe != 2'b00 |-> ctrl_link_oe == 2'b11)
		else $error("link drives data without owning control");
	a_no_reserved_code: assert property (ctrl_link_oe == 2'b11 |-> ctrl_link != 2'b11)
		else $error("link drives the reserved code");
	a_grant_one_period: assert property ($rose(grant_drv) |-> grant_drv [*2] ##1 ctrl_phy_oe == 2'b00)
		else $error("grant code not held one link period then released");
	a_idle_before_release: assert property ($fell(link_owns) |-> $past(ctrl_link) == LINK_REL)
		else $error("link released lines without idle code");
	a_phy_takes_back: assert property ($fell(link_owns) |-> ##[0:8] ctrl_phy_oe == 2'b11)
		else $error("phy did not take the lines back");
	a_req_bit_period: assert property ($changed(link_request_line) |=> $stable(link_request_line))
		else $error("request bit shorter than a link period");
	a_link_clk_runs: assert property ($past(resetn_i) |-> link_clk != $past(link_clk))
		else $error("link clock not toggling");
	a_code_on_tick: assert property (ctrl_phy_oe == 2'b11 && $stable(ctrl_phy_oe) && $changed(ctrl_phy) |-> link_clk)
		else $error("phy code changed off a link clock tick");
	c_grant: cover property ($rose(grant_drv));
	c_status: cover property (ctrl_phy_oe == 2'b11 && control_line == PHY_STATUS);
	c_receive: cover property (ctrl_phy_oe == 2'b11 && control_line == PHY_RECV);
	c_request: cover property ($rose(link_request_line));
endmodule
`default_nettype wire

// ===== sim/phy_link_request_interface_tb.sv
/*
 Testbench joining the phy and link ends: register writes and reads,
 every bus request type, grant with hold and transmit, receive, backplane.
 Assumes the package constants and the hand-over timing of both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_link_request_interface_tb import phy_link_pkg::*;;
	logic ref_clk_i, resetn_i, backplane_i, rx_valid_i, bus_won_i, req_start_i;
	logic tx_valid_i, tx_hold_i, req_valid_o, pending_o, tx_valid_o, tx_hold_o;
	logic req_busy_o, bus_pending_o, granted_o, rx_valid_o, stat_valid_o;
	logic [0:1] rx_data_i, tx_data_o, tx_data_i, rx_data_o;
	logic [2:0] req_type_i, req_type_o, cap_type;
	logic [1:0] req_speed_i, req_speed_o, cap_speed;
	logic [3:0] req_prio_i, req_addr_i, req_prio_o, stat_addr_o, cap_prio, cap_saddr;
	logic [7:0] req_data_i, stat_data_o, cap_sdata;
	logic [0:1] cap_rx, cap_tx;
	int n_req, n_stat, n_rx, n_tx, cycles, miscompares, compares;
	phy_link_if i_phy_link_if();
	phy_end i_phy_end(.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .lnk(i_phy_link_if), .backplane_i(backplane_i),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .bus_won_i(bus_won_i), .req_valid_o(req_valid_o),
		.req_type_o(req_type_o), .req_speed_o(req_speed_o), .req_prio_o(req_prio_o), .pending_o(pending_o),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_hold_o(tx_hold_o));
	link_end i_link_end(.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .lnk(i_phy_link_if), .backplane_i(backplane_i),
		.req_start_i(req_start_i), .req_type_i(req_type_i), .req_speed_i(req_speed_i), .req_prio_i(req_prio_i),
		.req_addr_i(req_addr_i), .req_data_i(req_data_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
		.tx_hold_i(tx_hold_i), .req_busy_o(req_busy_o), .bus_pending_o(bus_pending_o), .granted_o(granted_o),
		.rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .stat_valid_o(stat_valid_o),
		.stat_addr_o(stat_addr_o), .stat_data_o(stat_data_o));
	phy_link_assertions i_chk(.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_clk(i_phy_link_if.link_clk),
		.link_request_line(i_phy_link_if.link_request_line), .ctrl_phy(i_phy_link_if.ctrl_phy),
		.ctrl_phy_oe(i_phy_link_if.ctrl_phy_oe), .ctrl_link(i_phy_link_if.ctrl_link),
		.ctrl_link_oe(i_phy_link_if.ctrl_link_oe), .data_link_oe(i_phy_link_if.data_link_oe),
		.control_line(i_phy_link_if.control_line));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Pulses are latched here so a task that starts late cannot miss them
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (req_valid_o === 1'b1) begin
			n_req <= n_req + 1;
			cap_type <= req_type_o;
			cap_speed <= req_speed_o;
			cap_prio <= req_prio_o;
		end
		if (stat_valid_o === 1'b1) begin
			n_stat <= n_stat + 1;
			cap_saddr <= stat_addr_o;
			cap_sdata <= stat_data_o;
		end
		if (rx_valid_o === 1'b1) begin
			n_rx <= n_rx + 1;
			cap_rx <= rx_data_o;
		end
		if (tx_valid_o === 1'b1) begin
			n_tx <= n_tx + 1;
			cap_tx <= tx_data_o;
		end
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_more(ref int c, input int was);
		for (int n = 0; n < 300 && c == was; n++) @(posedge ref_clk_i);
	endtask
	task send_req(input logic [2:0] t, input logic [1:0] sp, input logic [3:0] pr, a, input logic [7:0] d);
		for (int n = 0; n < 100 && req_busy_o !== 1'b0; n++) @(posedge ref_clk_i);
		req_start_i <= 1'b1;
		{req_type_i, req_speed_i, req_prio_i, req_addr_i, req_data_i} <= {t, sp, pr, a, d};
		@(posedge ref_clk_i);
		req_start_i <= 1'b0;
		for (int n = 0; n < 10 && req_busy_o !== 1'b1; n++) @(posedge ref_clk_i);
		for (int n = 0; n < 100 && req_busy_o !== 1'b0; n++) @(posedge ref_clk_i);
		chk({7'h0, i_phy_link_if.link_request_line}, {7'h0, REQ_IDLE_LEVEL});
	endtask
	task rd_chk(input logic [3:0] a, input logic [7:0] exp);
		int was;
		was = n_stat;
		send_req(RQ_RD, 2'h0, 4'h0, a, 8'h00);
		wait_more(n_stat, was);
		chk({4'h0, cap_saddr}, {4'h0, a});
		chk(cap_sdata, exp);
	endtask
	task bus_req(input logic [2:0] t, input logic [1:0] sp, input logic [3:0] pr, input logic [1:0] exp_sp);
		int was;
		was = n_req;
		send_req(t, sp, pr, 4'h0, 8'h00);
		wait_more(n_req, was);
		chk({5'h0, cap_type}, {5'h0, t});
		chk({7'h0, bus_pending_o}, 8'h01);
		chk({6'h0, cap_speed}, {6'h0, exp_sp});
		if (backplane_i)
			chk({4'h0, cap_prio}, {4'h0, ((t == RQ_FAIR) ? pr : PRIO_FAIR)});
		tx_hold_i <= 1'b1;
		bus_won_i <= 1'b1;
		for (int n = 0; n < 50 && granted_o !== 1'b1; n++) @(posedge ref_clk_i);
		bus_won_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		chk({7'h0, tx_hold_o}, 8'h01);
		was = n_tx;
		tx_valid_i <= 1'b1;
		tx_data_i <= 2'b01;
		repeat (2) @(posedge ref_clk_i);
		tx_valid_i <= 1'b0;
		tx_hold_i <= 1'b0;
		wait_more(n_tx, was);
		chk({6'h0, cap_tx}, 8'h01);
		for (int n = 0; n < 50 && granted_o !== 1'b0; n++) @(posedge ref_clk_i);
		chk({5'h0, bus_pending_o, pending_o, granted_o}, 8'h00);
	endtask
	task do_reset(input logic bp);
		resetn_i <= 1'b0;
		backplane_i <= bp;
		repeat (6) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
	endtask
	initial begin
		int was;
		{resetn_i, backplane_i, rx_valid_i, bus_won_i, req_start_i, tx_valid_i, tx_hold_i} = 7'h00;
		{rx_data_i, tx_data_i, req_type_i, req_speed_i, req_prio_i, req_addr_i, req_data_i} = 25'h0;
		{n_req, n_stat, n_rx, n_tx, cycles, miscompares, compares} = '0;
		do_reset(1'b0);
		rd_chk(4'h4, REG_RESET);
		send_req(RQ_WR, 2'h0, 4'h0, 4'h3, 8'ha5);
		send_req(RQ_WR, 2'h0, 4'h0, 4'hf, 8'h5a);
		rd_chk(4'h3, 8'ha5);
		rd_chk(4'hf, 8'h5a);
		for (int t = 0; t < 4; t++)
			bus_req(3'(t), 2'(t), 4'h0, 2'(t));
		was = n_rx;
		rx_valid_i <= 1'b1;
		rx_data_i <= 2'b10;
		repeat (2) @(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
		wait_more(n_rx, was);
		chk({6'h0, cap_rx}, 8'h02);
		do_reset(1'b1);
		bus_req(RQ_FAIR, 2'h3, 4'h5, SPEED_BACKPLANE);
		bus_req(RQ_FAIR, 2'h0, PRIO_FAIR, SPEED_BACKPLANE);
		bus_req(RQ_PRI, 2'h0, PRIO_RSVD, SPEED_BACKPLANE);
		rd_chk(4'h3, REG_RESET);
		close_out();
	end
endmodule
`default_nettype wire
